// ### pgss_checker_assertions.sv
// Assertion checker bound to the power-good start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module pgss_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Inputs of the sequencer.
  input wire logic [1:0] pin_function,
  input wire logic [1:0] config_select,
  input wire logic supplies_valid,
  input wire logic power_is_good,
  input wire logic load_done,
  // Outputs of the sequencer.
  input wire pgss_pkg::pgss_load_type load_cmd,
  input wire logic analog_pll_enable,
  input wire logic outputs_enable,
  input wire logic core_reset_n,
  input wire logic config_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_gate; outputs_enable |-> analog_pll_enable; endproperty
  a_gate: assert property (p_gate)
    else $error("outputs on with pll off");
  property p_pause;
    (pin_function inside {2'h1, 2'h2} && !power_is_good)[*8]
      |-> !outputs_enable;
  endproperty
  a_pause: assert property (p_pause)
    else $error("outputs on while pin low");
  property p_pdn;
    (pin_function == 2'h1 && !power_is_good)[*8] |-> !analog_pll_enable;
  endproperty
  a_pdn: assert property (p_pdn)
    else $error("pll on in power-down");
  property p_sel;
    $rose(load_cmd.load_req) && $stable(config_select)
      |-> load_cmd.load_sel == config_select;
  endproperty
  a_sel: assert property (p_sel)
    else $error("load select wrong");
  property p_hold; load_cmd.load_req && !load_done |=> load_cmd.load_req;
  endproperty
  a_hold: assert property (p_hold)
    else $error("load request dropped early");
  property p_run;
    load_cmd.load_req && load_done && supplies_valid |=> outputs_enable;
  endproperty
  a_run: assert property (p_run)
    else $error("no run after load");
  property p_rst; !core_reset_n |=> core_reset_n; endproperty
  a_rst: assert property (p_rst)
    else $error("restart pulse too long");
  property p_rfn; !core_reset_n |-> pin_function == 2'h2; endproperty
  a_rfn: assert property (p_rfn)
    else $error("restart pulse in wrong mode");
  property p_err; config_error == (pin_function == 2'h3); endproperty
  a_err: assert property (p_err)
    else $error("config error flag wrong");
  // Main scenarios reached.
  c_run: cover property ($rose(outputs_enable));
  c_rst: cover property (!core_reset_n);
  c_load: cover property (load_cmd.load_req && load_done);
endmodule
////////////////////////////////////////////////////////////////////////
bind pgss_sequencer pgss_checker u_chk (.core_clk, .rst_n, .pin_function,
  .config_select, .supplies_valid, .power_is_good, .load_done, .load_cmd,
  .analog_pll_enable, .outputs_enable, .core_reset_n, .config_error);
`default_nettype wire

// ### pgss_ctrl_model.sv
// Power-management controller model that drives the power-good pin.
`timescale 1ns/1ps
`default_nettype none
`include "pgss_defines.svh"
module pgss_ctrl_model #(
  parameter int HOLD = `PGSS_HOLD_CYCLES
) (
  // Clock, supply status and the bench's wish for the pin.
  input wire logic core_clk,
  input wire logic supplies_valid,
  input wire logic want_good,
  // Power-good pin toward the device.
  output logic power_is_good
);
  int cnt = 0;
  // Counts cycles since the supplies became valid.
  always @(negedge core_clk)
    cnt <= supplies_valid ? (cnt < HOLD ? cnt + 1 : cnt) : 0;
  // The pin is low from the start and through the hold time.
  assign power_is_good = want_good && cnt >= HOLD;
endmodule
`default_nettype wire

// ### pgss_defines.svh
// Constants of the power-good start-up sequencer.
`ifndef PGSS_DEFINES_SVH
`define PGSS_DEFINES_SVH

// Pin function codes.
`define PGSS_FUNC_NONE 2'h0
`define PGSS_FUNC_POWER_DOWN_REQUEST_N 2'h1
`define PGSS_FUNC_RESTART 2'h2

// Least low time of the power-good pin, in ns, and the core clock period.
`define PGSS_HOLD_NS 200000
`define PGSS_CLK_NS 40
`define PGSS_HOLD_CYCLES ((`PGSS_HOLD_NS + `PGSS_CLK_NS - 1) / `PGSS_CLK_NS)

`endif

// ### pgss_pkg.sv
// Types of the power-good start-up sequencer.
`default_nettype none
package pgss_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    PGSS_WAIT_SUPPLY,
    PGSS_PAUSED,
    PGSS_LOAD,
    PGSS_RUN,
    PGSS_POWER_DOWN,
    PGSS_RESTART
  } pgss_state_type;

  // Requests to the configuration loader.
  typedef struct packed {
    logic load_req;
    logic [1:0] load_sel;
  } pgss_load_type;

endpackage
`default_nettype wire

// ### pgss_sequencer.sv
// Start-up, power-down and restart sequencer driven by a power-good pin.
`timescale 1ns/1ps
`default_nettype none
`include "pgss_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module pgss_sequencer #(
  parameter int HOLD_CYCLES = `PGSS_HOLD_CYCLES
) (
  // Clock and power-on reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration of the general purpose pin and the select pins.
  input wire logic [1:0] pin_function,
  input wire logic [1:0] config_select,
  // Supply status and the power-good pin from the controller.
  input wire logic supplies_valid,
  input wire logic power_is_good,
  // Loader handshake.
  output pgss_pkg::pgss_load_type load_cmd,
  input wire logic load_done,
  // Device controls.
  output logic analog_pll_enable,
  output logic outputs_enable,
  output logic core_reset_n,
  output logic config_error
);

  //////////////////////////////////////////////////////////////////////////
  // Three-stage input sampling of the pin.
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic pin_level_reg;
  logic pin_level_next;

  // Shift in the pin; the level moves once the later two stages agree.
  always_comb begin
    sync_next = {sync_reg[1:0], power_is_good};
    pin_level_next = pin_level_reg;
    if (sync_reg[2] == sync_reg[1]) begin
      pin_level_next = sync_reg[2];
    end
  end

  // Pin sampling registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= 3'h0;
      pin_level_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      pin_level_reg <= pin_level_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer.
  pgss_pkg::pgss_state_type state_reg;
  pgss_pkg::pgss_state_type state_next;
  logic loaded_reg;
  logic loaded_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic req_reg;
  logic req_next;
  logic [17:0] hold_reg;
  logic [17:0] hold_next;
  logic use_pin;
  logic bad_func;
  logic hold_done;

  // Both functions at once, or an unknown code, leaves the pin unused.
  assign bad_func = (pin_function != `PGSS_FUNC_NONE) &&
                    (pin_function != `PGSS_FUNC_POWER_DOWN_REQUEST_N) &&
                    (pin_function != `PGSS_FUNC_RESTART);
  assign use_pin = (pin_function == `PGSS_FUNC_POWER_DOWN_REQUEST_N) ||
                   (pin_function == `PGSS_FUNC_RESTART);
  // The low-time count is met once it reaches the parameter; the count
  // saturates there, so HOLD_CYCLES must fit in the 18-bit counter.
  assign hold_done = (hold_reg >= 18'(HOLD_CYCLES));

  // Next state, load request and low-time counter.
  always_comb begin
    state_next = state_reg;
    loaded_next = loaded_reg;
    sel_next = sel_reg;
    req_next = 1'b0;
    hold_next = hold_reg;
    // Count cycles of low pin with supplies valid. A supply loss starts the
    // count again, so a rise that comes before the least low time has run
    // out is not acted upon until the pin has been low long enough.
    if (!supplies_valid) begin
      hold_next = 18'h0;
    end else if (!pin_level_reg && !hold_done) begin
      hold_next = hold_reg + 18'h1;
    end
    unique case (state_reg)
      pgss_pkg::PGSS_WAIT_SUPPLY: begin
        if (supplies_valid) begin
          state_next = use_pin ? pgss_pkg::PGSS_PAUSED
                               : pgss_pkg::PGSS_LOAD;
          req_next = !use_pin;
          sel_next = config_select;
        end
      end
      pgss_pkg::PGSS_PAUSED: begin
        // Held here while the pin is low.
        if (pin_level_reg && supplies_valid && hold_done) begin
          if (loaded_reg &&
              pin_function == `PGSS_FUNC_POWER_DOWN_REQUEST_N) begin
            state_next = pgss_pkg::PGSS_RUN;
          end else begin
            state_next = pgss_pkg::PGSS_LOAD;
            req_next = 1'b1;
            sel_next = config_select;
          end
        end
      end
      pgss_pkg::PGSS_LOAD: begin
        req_next = !load_done;
        if (load_done) begin
          loaded_next = 1'b1;
          state_next = pgss_pkg::PGSS_RUN;
        end
      end
      pgss_pkg::PGSS_RUN: begin
        if (!supplies_valid) begin
          state_next = pgss_pkg::PGSS_WAIT_SUPPLY;
        end else if (use_pin && !pin_level_reg) begin
          state_next = (pin_function == `PGSS_FUNC_POWER_DOWN_REQUEST_N)
                       ? pgss_pkg::PGSS_POWER_DOWN
                       : pgss_pkg::PGSS_RESTART;
        end
      end
      pgss_pkg::PGSS_POWER_DOWN: begin
        if (pin_level_reg) begin
          state_next = pgss_pkg::PGSS_RUN;
        end
      end
      pgss_pkg::PGSS_RESTART: begin
        // Forget the configuration so the next rise reloads it.
        loaded_next = 1'b0;
        state_next = pgss_pkg::PGSS_PAUSED;
      end
      default: begin
        state_next = pgss_pkg::PGSS_WAIT_SUPPLY;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pgss_pkg::PGSS_WAIT_SUPPLY;
      loaded_reg <= 1'b0;
      sel_reg <= 2'h0;
      req_reg <= 1'b0;
      hold_reg <= 18'h0;
    end else begin
      state_reg <= state_next;
      loaded_reg <= loaded_next;
      sel_reg <= sel_next;
      req_reg <= req_next;
      hold_reg <= hold_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output controls.
  logic pll_on_reg;
  logic pll_on_next;
  logic out_en_reg;
  logic out_en_next;
  logic core_reset_n_reg;
  logic core_reset_n_next;

  // Controls are worked out from the next state, so they switch at the
  // same edge as the state and come straight from flip-flops.
  always_comb begin
    pll_on_next = (state_next == pgss_pkg::PGSS_LOAD) ||
                  (state_next == pgss_pkg::PGSS_RUN);
    out_en_next = (state_next == pgss_pkg::PGSS_RUN);
    core_reset_n_next = (state_next != pgss_pkg::PGSS_RESTART);
  end

  // Output control registers; reset leaves the clocks gated, the PLL off.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_on_reg <= 1'b0;
      out_en_reg <= 1'b0;
      core_reset_n_reg <= 1'b1;
    end else begin
      pll_on_reg <= pll_on_next;
      out_en_reg <= out_en_next;
      core_reset_n_reg <= core_reset_n_next;
    end
  end

  // Loader request and the select captured when the load began.
  always_comb begin
    load_cmd.load_req = req_reg;
    load_cmd.load_sel = sel_reg;
  end

  // Drive the device controls.
  assign analog_pll_enable = pll_on_reg;
  assign outputs_enable = out_en_reg;
  assign core_reset_n = core_reset_n_reg;
  // The error flag follows the static function code with no delay.
  assign config_error = bad_func;

endmodule
`default_nettype wire

// ### tb_pgss_sequencer.sv
// Self-checking testbench of the power-good start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "pgss_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_pgss_sequencer;
  logic core_clk = 0, rst_n = 0, supplies_valid = 0, want_good = 0;
  logic load_done = 0, lr_q = 0;
  logic [1:0] pin_function = 2'h1, config_select = 2'h0, sel;
  logic power_is_good, analog_pll_enable, outputs_enable, core_reset_n;
  logic config_error;
  pgss_pkg::pgss_load_type load_cmd;
  int failures = 0, comparisons = 0, loads = 0, pulses = 0;
  pgss_sequencer #(.HOLD_CYCLES(4)) dut (.core_clk, .rst_n, .pin_function,
    .config_select, .supplies_valid, .power_is_good, .load_cmd, .load_done,
    .analog_pll_enable, .outputs_enable, .core_reset_n, .config_error);
  pgss_ctrl_model #(.HOLD(4)) ctrl (.core_clk, .supplies_valid, .want_good,
    .power_is_good);
  initial forever #20 core_clk = ~core_clk;
  // Loader answers after a random stall; loads and restarts are counted.
  always @(negedge core_clk) begin
    load_done <= load_cmd.load_req && ($urandom % 3 == 0);
    lr_q <= load_cmd.load_req;
    if (load_cmd.load_req && !lr_q) loads++;
    if (!core_reset_n) pulses++;
  end
  task automatic final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n); repeat (n) @(negedge core_clk); endtask
  // Loads expected after a number of rises in one mode: power-down mode
  // loads on the first rise only, restart mode on every rise.
  function automatic int exp_loads(input logic [1:0] f, input int rises);
    return (f == `PGSS_FUNC_POWER_DOWN_REQUEST_N) ? 1 : rises;
  endfunction
  // The error flag is expected when both functions are asked for at once.
  function automatic logic exp_err(input logic [1:0] f);
    return f == (`PGSS_FUNC_POWER_DOWN_REQUEST_N | `PGSS_FUNC_RESTART);
  endfunction
  // Resets the device with a new pin function and supplies off.
  task automatic go(input logic [1:0] f);
    rst_n = 0; pin_function = f; want_good = 0; supplies_valid = 0;
    wt(4); rst_n = 1; wt(2);
  endtask
  // Raises the pin and waits for the outputs to run.
  task automatic up;
    want_good = 1;
    for (int i = 0; i < 100 && outputs_enable !== 1'b1; i++) wt(1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h511054e6));
    go(2'h1); sel = 2'($urandom); config_select = sel; supplies_valid = 1;
    wt(20); `CHK("paused", 1'b0, outputs_enable)
    up; `CHK("run", 1'b1, outputs_enable)
    `CHK("select", sel, load_cmd.load_sel)
    want_good = 0; wt(1); want_good = 1; wt(10);
    `CHK("glitch", 1'b1, outputs_enable)
    for (int r = 2; r < 5; r++) begin
      want_good = 0; config_select = ~sel; wt(12);
      `CHK("pll", 1'b0, analog_pll_enable)
      up; `CHK("loads", exp_loads(2'h1, r), loads)
      `CHK("resume", 1'b1, outputs_enable)
    end
    // Supply loss while running: gated, then back with no new load.
    supplies_valid = 0; wt(8);
    `CHK("supply loss", 1'b0, outputs_enable)
    supplies_valid = 1; up; `CHK("kept", exp_loads(2'h1, 5), loads)
    `CHK("back", 1'b1, outputs_enable)
    go(2'h2); supplies_valid = 1;
    `CHK("legal", exp_err(2'h2), config_error)
    for (int k = 0; k < 3; k++) begin
      sel = 2'($urandom); config_select = sel; up;
      `CHK("reload", 1 + exp_loads(2'h2, k + 1), loads)
      `CHK("new select", sel, load_cmd.load_sel)
      want_good = 0; wt(12); `CHK("restart", k + 1, pulses)
    end
    go(2'h0); wt(10); `CHK("gated", 1'b0, outputs_enable)
    supplies_valid = 1; up; `CHK("ungated", 1'b1, outputs_enable)
    go(2'h3); `CHK("illegal", exp_err(2'h3), config_error)
    final_report;
  end
  // Cuts a hung run short.
  initial begin repeat (5000) @(posedge core_clk); failures++; final_report; end
endmodule
`default_nettype wire
